// *** hdl/eef_defer_timer.sv ***
`timescale 1ns/1ps
module eef_defer_timer #(
	parameter int LIMIT = eef_pkg::DEFER_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic defer_i,
	output logic      expired_o
);
	typedef struct packed {
		logic [21:0] cnt;
		logic        exp;
	} eef_dt_s;
	eef_dt_s st_r;
	eef_dt_s st_nxt;
	localparam logic [21:0] LIM = 22'(LIMIT);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.exp = 1'b0;
		if (!defer_i)
		begin
			st_nxt.cnt = '0;
		end
		else if (st_r.cnt == LIM - 22'h000001)
		begin
			st_nxt.exp = 1'b1;
			st_nxt.cnt = '0;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + 22'h000001;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end
	assign expired_o = st_r.exp;
endmodule : eef_defer_timer

// *** hdl/eef_pkg.sv ***
// How it works
// - Overflow or count 255 aborts frame, flags
// - Receive error flag sticky until clear
// - Pin low when flag, enable, global set
// - Five transmit abort causes set error flag
// - Transmit error flag sticky until clear
// - Abort clears request, sets status, stores vector
// - Transmit error also sets transmit done
// - Full duplex: only oversize abort counts
// - Request falling edge sets transmit done
// - Transmit done flag sticky until clear
// - Link flag mirrors phy flag once enabled
// - Phy global flag equals phy link flag
// - Link flag read-only, needs two enables
// - Phy request read clears all link flags
// - DMA start falling edge sets done flag
// - DMA done flag sticky until clear
// - Pending flag equals nonzero packet count
// - Pin asserts while packet count nonzero
// - Wake frame counts one, pending, pin low
package eef_pkg;

	localparam int CLK_MHZ = 125;
	localparam int CNT_W = 8;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [12:0] PTR_RST = 13'h0000;
	localparam logic [12:0] PTR_STEP = 13'h0001;

	// Flag bit positions
	localparam int RXE_BIT = 0;
	localparam int TXE_BIT = 1;
	localparam int TXD_BIT = 3;
	localparam int LNK_BIT = 4;
	localparam int DMA_BIT = 5;
	localparam int PKT_BIT = 6;
	localparam int GLB_BIT = 7;
	localparam logic [7:0] FLAG_RST = 8'h00;

	// Deferral limit in ns and derived cycle count
	localparam longint DEFER_NS = 64'd2428700;
	localparam int DEFER_CYC = int'((DEFER_NS * CLK_MHZ) / 1000);

endpackage : eef_pkg

// *** hdl/eef_status_vec.sv ***
`timescale 1ns/1ps
// Holds the abort status vector and the address it belongs at
module eef_status_vec (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        we_i,
	input  wire logic [12:0] end_ptr_i,
	input  wire logic [7:0]  vec_i,
	output logic [12:0]      addr_o,
	output logic [7:0]       data_o
);
	typedef struct packed {
		logic [12:0] addr;
		logic [7:0]  data;
	} eef_sv_s;
	eef_sv_s st_r;
	eef_sv_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (we_i)
		begin
			st_nxt.addr = end_ptr_i + eef_pkg::PTR_STEP;
			st_nxt.data = vec_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			st_r <= '{addr: eef_pkg::PTR_RST, data: 8'h00};
		else
			st_r <= st_nxt;
	end
	assign addr_o = st_r.addr;
	assign data_o = st_r.data;
endmodule : eef_status_vec

// *** hdl/eef_top.sv ***
`timescale 1ns/1ps
module eef_top #(
	parameter int DEFER_LIMIT = eef_pkg::DEFER_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Enables
	input  wire logic        global_irq_enable_i,
	input  wire logic        rx_error_enable_i,
	input  wire logic        tx_error_enable_i,
	input  wire logic        tx_done_enable_i,
	input  wire logic        link_change_enable_i,
	input  wire logic        dma_done_enable_i,
	input  wire logic        packet_pending_enable_i,
	input  wire logic        phy_link_irq_enable_i,
	input  wire logic        phy_global_irq_enable_i,
	// Host flag clears (bit field clear command), one-cycle pulses
	input  wire logic        clr_rx_error_i,
	input  wire logic        clr_tx_error_i,
	input  wire logic        clr_tx_done_i,
	input  wire logic        clr_dma_done_i,
	input  wire logic        clr_tx_abort_i,
	// Receive side
	input  wire logic        rx_frame_end_i,
	input  wire logic        rx_frame_good_i,
	input  wire logic        rx_buffer_full_i,
	input  wire logic        rx_count_dec_i,
	// Transmit side
	input  wire logic        tx_request_set_i,
	input  wire logic        tx_request_clr_i,
	input  wire logic        tx_complete_i,
	input  wire logic        full_duplex_i,
	input  wire logic        tx_excess_coll_i,
	input  wire logic        tx_window_coll_i,
	input  wire logic        tx_late_coll_i,
	input  wire logic        tx_deferring_i,
	input  wire logic        defer_forever_i,
	input  wire logic        tx_oversize_i,
	input  wire logic        huge_frame_enable_i,
	input  wire logic        per_packet_override_i,
	input  wire logic        per_packet_huge_enable_i,
	input  wire logic [12:0] tx_end_pointer_i,
	input  wire logic [7:0]  tx_status_i,
	// PHY and DMA
	input  wire logic        phy_link_event_i,
	input  wire logic        phy_irq_read_i,
	input  wire logic        dma_start_i,
	// Outputs
	output logic             irq_n_o,
	output logic [7:0]       event_request_o,
	output logic [7:0]       rx_packet_count_o,
	output logic             rx_abort_o,
	output logic             tx_request_o,
	output logic             tx_abort_status_o,
	output logic             phy_global_flag_o,
	output logic             phy_link_flag_o,
	output logic [12:0]      status_addr_o,
	output logic [7:0]       status_data_o
);
	typedef struct packed {
		logic       rxe;
		logic       txe;
		logic       txd;
		logic       dmd;
		logic       plf;
		logic       txr;
		logic       abt;
		logic       dma_d;
		logic       rxab;
		logic [7:0] cnt;
	} eef_st_s;

	eef_st_s st_r;
	eef_st_s st_nxt;
	logic    defer_exp;
	logic    phy_en;
	logic    link_flag;
	logic    rx_drop;
	logic    rx_keep;
	logic    tx_fault;
	logic    tx_abort;
	logic    any_irq;

	// ==========================================
	// Sub blocks
	eef_defer_timer #(
		.LIMIT(DEFER_LIMIT)
	) u_defer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.defer_i  (tx_deferring_i & st_r.txr & ~full_duplex_i),
		.expired_o(defer_exp)
	);

	eef_status_vec u_vec (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.we_i     (tx_abort),
		.end_ptr_i(tx_end_pointer_i),
		.vec_i    (tx_status_i),
		.addr_o   (status_addr_o),
		.data_o   (status_data_o)
	);

	// ==========================================
	// Event decode
	always_comb
	begin
		phy_en = phy_link_irq_enable_i & phy_global_irq_enable_i;
		link_flag = phy_en & st_r.plf;
		rx_drop = rx_frame_end_i & (rx_buffer_full_i | st_r.cnt == eef_pkg::CNT_MAX);
		rx_keep = rx_frame_end_i & rx_frame_good_i & ~rx_drop;
		// Collision and deferral causes impossible in full duplex
		tx_fault = (~full_duplex_i & (tx_excess_coll_i | tx_window_coll_i |
			tx_late_coll_i | (defer_exp & ~defer_forever_i))) |
			(tx_oversize_i & ~huge_frame_enable_i &
			~(per_packet_override_i & per_packet_huge_enable_i));
		tx_abort = st_r.txr & tx_fault;
	end

	// ==========================================
	// State update
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rxab = rx_drop;
		// Set wins over a same-cycle clear
		st_nxt.rxe = rx_drop | (st_r.rxe & ~clr_rx_error_i);
		st_nxt.txe = tx_abort | (st_r.txe & ~clr_tx_error_i);
		if (tx_abort)
		begin
			st_nxt.txr = 1'b0;
			st_nxt.abt = 1'b1;
		end
		else if (tx_complete_i | tx_request_clr_i)
			st_nxt.txr = 1'b0;
		else if (tx_request_set_i)
			st_nxt.txr = 1'b1;
		if (clr_tx_abort_i & ~tx_abort)
			st_nxt.abt = 1'b0;
		// Falling edge of request, abort included
		st_nxt.txd = (st_r.txr & ~st_nxt.txr) | (st_r.txd & ~clr_tx_done_i);
		// Read clear of phy request re-arms detection
		st_nxt.plf = phy_link_event_i | (st_r.plf & ~phy_irq_read_i);
		st_nxt.dma_d = dma_start_i;
		st_nxt.dmd = (st_r.dma_d & ~dma_start_i) | (st_r.dmd & ~clr_dma_done_i);
		if (rx_keep & ~rx_count_dec_i)
			st_nxt.cnt = st_r.cnt + 8'h01;
		else if (rx_count_dec_i & ~rx_keep & st_r.cnt != 8'h00)
			st_nxt.cnt = st_r.cnt - 8'h01;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// ==========================================
	// Outputs
	always_comb
	begin
		event_request_o = eef_pkg::FLAG_RST;
		event_request_o[eef_pkg::RXE_BIT] = st_r.rxe;
		event_request_o[eef_pkg::TXE_BIT] = st_r.txe;
		event_request_o[eef_pkg::TXD_BIT] = st_r.txd;
		event_request_o[eef_pkg::LNK_BIT] = link_flag;
		event_request_o[eef_pkg::DMA_BIT] = st_r.dmd;
		event_request_o[eef_pkg::PKT_BIT] = st_r.cnt != 8'h00;
		any_irq = global_irq_enable_i & (
			(st_r.rxe & rx_error_enable_i) |
			(st_r.txe & tx_error_enable_i) |
			(st_r.txd & tx_done_enable_i) |
			(link_flag & link_change_enable_i) |
			(st_r.dmd & dma_done_enable_i) |
			((st_r.cnt != 8'h00) & packet_pending_enable_i));
		event_request_o[eef_pkg::GLB_BIT] = any_irq;
	end

	assign irq_n_o = ~any_irq;
	assign rx_packet_count_o = st_r.cnt;
	assign rx_abort_o = st_r.rxab;
	assign tx_request_o = st_r.txr;
	assign tx_abort_status_o = st_r.abt;
	assign phy_global_flag_o = st_r.plf;
	assign phy_link_flag_o = st_r.plf;

	// ==========================================
	// Assertions
	rx_err_set_a: assert property (@(posedge clk_i) disable iff (rst_i) rx_drop |=> st_r.rxe)
		else $error("rx error not set");
	rx_err_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.rxe & ~clr_rx_error_i |=> st_r.rxe)
		else $error("rx error dropped");
	irq_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(st_r.dmd & dma_done_enable_i & global_irq_enable_i) |-> !irq_n_o)
		else $error("irq pin not low");
	tx_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_abort |=> !st_r.txr && st_r.abt && st_r.txe && st_r.txd)
		else $error("abort effects missing");
	txd_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(st_r.txr) |-> st_r.txd)
		else $error("tx done missed");
	link_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!phy_en |-> !event_request_o[eef_pkg::LNK_BIT])
		else $error("link flag without enables");
	phy_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		phy_irq_read_i & ~phy_link_event_i |=> !st_r.plf)
		else $error("phy read no clear");
	dma_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(dma_start_i) |=> st_r.dmd)
		else $error("dma done missed");
	pkt_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_keep & ~rx_count_dec_i |=> event_request_o[eef_pkg::PKT_BIT] &&
		rx_packet_count_o == $past(rx_packet_count_o) + 8'h01)
		else $error("pending flag mismatch");
	tx_err_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.txe & ~clr_tx_error_i |=> st_r.txe)
		else $error("tx error dropped");
	txd_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.txd & ~clr_tx_done_i |=> st_r.txd)
		else $error("tx done dropped");
	dmd_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.dmd & ~clr_dma_done_i |=> st_r.dmd)
		else $error("dma done dropped");
	txe_txd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(st_r.txe) |-> st_r.txd)
		else $error("tx error without tx done");
	duplex_a: assert property (@(posedge clk_i) disable iff (rst_i)
		st_r.txr & full_duplex_i & ~tx_oversize_i |=> !$rose(st_r.txe))
		else $error("duplex abort not oversize");
	link_mirror_a: assert property (@(posedge clk_i) disable iff (rst_i)
		phy_en |-> event_request_o[eef_pkg::LNK_BIT] == phy_global_flag_o)
		else $error("link flag not mirroring");
	rx_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_drop & ~rx_count_dec_i |=> rx_packet_count_o == $past(rx_packet_count_o))
		else $error("dropped frame counted");
	status_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
		tx_abort |=> status_addr_o == $past(tx_end_pointer_i) + eef_pkg::PTR_STEP &&
		status_data_o == $past(tx_status_i))
		else $error("status vector wrong");
	pkt_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(rx_packet_count_o != 8'h00) & packet_pending_enable_i & global_irq_enable_i
		|-> !irq_n_o)
		else $error("pending irq pin high");
	irq_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!global_irq_enable_i |-> irq_n_o)
		else $error("irq pin stuck low");

	rx_drop_c: cover property (@(posedge clk_i) disable iff (rst_i) rx_drop);
	tx_abort_c: cover property (@(posedge clk_i) disable iff (rst_i) tx_abort);
	wake_c: cover property (@(posedge clk_i) disable iff (rst_i)
		rx_keep && st_r.cnt == 8'h00 ##1 !irq_n_o);
	dma_done_c: cover property (@(posedge clk_i) disable iff (rst_i) $fell(dma_start_i));
	link_c: cover property (@(posedge clk_i) disable iff (rst_i)
		event_request_o[eef_pkg::LNK_BIT] && !irq_n_o);
endmodule : eef_top

// *** tb/eef_host_model.sv ***
`timescale 1ns/1ps
// =====================
// Host side of the flag logic
module eef_host_model (
	input  wire logic clk_i,
	output logic [4:0] clr_o,
	output logic       dec_o,
	output logic       phy_read_o
);
	initial
	begin
		clr_o = 5'h00;
		dec_o = 1'b0;
		phy_read_o = 1'b0;
	end
	// Bit field clear, one cycle wide
	task automatic bfc(input logic [4:0] mask);
		@(posedge clk_i) #1 clr_o = mask;
		@(posedge clk_i) #1 clr_o = 5'h00;
	endtask : bfc
	// Free buffer space one frame at a time
	task automatic drain(input int n);
		repeat (n)
		begin
			@(posedge clk_i) #1 dec_o = 1'b1;
			@(posedge clk_i) #1 dec_o = 1'b0;
		end
	endtask : drain
	task automatic phy_read();
		@(posedge clk_i) #1 phy_read_o = 1'b1;
		@(posedge clk_i) #1 phy_read_o = 1'b0;
	endtask : phy_read
endmodule : eef_host_model

// *** tb/eef_top_tb.sv ***
`timescale 1ns/1ps
module eef_top_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [8:0]  en = 9'h000;
	logic [4:0]  cause = 5'h00;
	logic        fe = 0, fg = 0, bf = 0, rs = 0, rc = 0, cmp = 0, fd = 0, ev = 0, dma = 0;
	logic        dfv = 0, hfe = 0, ppo = 0, pph = 0;
	logic [12:0] ptr = 13'h1fff;
	logic [7:0]  stat = 8'ha5;
	logic [4:0]  clr;
	logic        dec, prd, irq_n, abrt, req, tabs, pg, pl;
	logic [7:0]  evr, cnt, sdat;
	logic [12:0] sadr;
	int          n_errors = 0;
	int          num_checks = 0;
	int          cyc = 0;
	always #4 clk_i = ~clk_i;
	eef_top #(.DEFER_LIMIT(20)) i_dut (.clk_i, .rst_i,
		.global_irq_enable_i(en[0]), .rx_error_enable_i(en[1]), .tx_error_enable_i(en[2]),
		.tx_done_enable_i(en[3]), .link_change_enable_i(en[4]), .dma_done_enable_i(en[5]),
		.packet_pending_enable_i(en[6]), .phy_link_irq_enable_i(en[7]),
		.phy_global_irq_enable_i(en[8]), .clr_rx_error_i(clr[0]), .clr_tx_error_i(clr[1]),
		.clr_tx_done_i(clr[2]), .clr_dma_done_i(clr[3]), .clr_tx_abort_i(clr[4]),
		.rx_frame_end_i(fe), .rx_frame_good_i(fg), .rx_buffer_full_i(bf), .rx_count_dec_i(dec),
		.tx_request_set_i(rs), .tx_request_clr_i(rc), .tx_complete_i(cmp), .full_duplex_i(fd),
		.tx_excess_coll_i(cause[0]), .tx_window_coll_i(cause[1]), .tx_late_coll_i(cause[2]),
		.tx_deferring_i(cause[3]), .defer_forever_i(dfv), .tx_oversize_i(cause[4]),
		.huge_frame_enable_i(hfe), .per_packet_override_i(ppo),
		.per_packet_huge_enable_i(pph), .tx_end_pointer_i(ptr), .tx_status_i(stat),
		.phy_link_event_i(ev), .phy_irq_read_i(prd), .dma_start_i(dma), .irq_n_o(irq_n),
		.event_request_o(evr), .rx_packet_count_o(cnt), .rx_abort_o(abrt), .tx_request_o(req),
		.tx_abort_status_o(tabs), .phy_global_flag_o(pg), .phy_link_flag_o(pl),
		.status_addr_o(sadr), .status_data_o(sdat));
	eef_host_model i_host (.clk_i, .clr_o(clr), .dec_o(dec), .phy_read_o(prd));
	// =====================
	// Shared helpers
	task automatic cy(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cy
	task automatic chk(input string nm, input logic [12:0] s, input logic [12:0] e);
		num_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			report_and_stop();
		end
	end
	// =====================
	// Scenarios
	task automatic t_rx_error();
		en = 9'h003;
		bf = 1;
		fe = 1;
		cy(1);
		bf = 0;
		fe = 0;
		chk("abort", abrt, 1);
		cy(3);
		chk("abort", abrt, 0);
		chk("rx_err", evr[0], 1);
		chk("irq_n", irq_n, 0);
		chk("any_irq", evr[7], 1);
		chk("reserved", evr[2], 0);
		i_host.bfc(5'h01);
		chk("rx_err", evr[0], 0);
		chk("irq_n", irq_n, 1);
	endtask : t_rx_error
	task automatic t_packets();
		en = 9'h041;
		fe = 1;
		fg = 1;
		cy(255);
		chk("count", cnt, 8'hff);
		chk("irq_n", irq_n, 0);
		cy(1);
		fe = 0;
		fg = 0;
		chk("abort", abrt, 1);
		chk("rx_err", evr[0], 1);
		chk("count", cnt, 8'hff);
		i_host.drain(255);
		chk("pending", evr[6], 0);
		i_host.bfc(5'h01);
		// Wake-up arming order
		en = 9'h041;
		fe = 1;
		fg = 1;
		cy(1);
		fe = 0;
		fg = 0;
		chk("count", cnt, 1);
		chk("pending", evr[6], 1);
		chk("irq_n", irq_n, 0);
		i_host.drain(1);
	endtask : t_packets
	task automatic t_tx_abort(input int i);
		en = 9'h00d;
		ptr = 13'h1ffd + 13'(i);
		stat = 8'ha0 + 8'(i);
		rs = 1;
		cy(1);
		rs = 0;
		cause = 5'h01 << i;
		for (int k = 0; k < 40 && req === 1'b1; k++) cy(1);
		cause = 5'h00;
		chk("req", req, 0);
		chk("abort_st", tabs, 1);
		chk("tx_err", evr[1], 1);
		chk("tx_done", evr[3], 1);
		chk("st_addr", sadr, ptr + 13'h0001);
		chk("st_data", sdat, stat);
		chk("irq_n", irq_n, 0);
		cy(2);
		chk("tx_err", evr[1], 1);
		i_host.bfc(5'h16);
		chk("irq_n", irq_n, 1);
		chk("abort_st", tabs, 0);
	endtask : t_tx_abort
	task automatic t_tx_permit();
		en = 9'h001;
		rs = 1;
		cy(1);
		rs = 0;
		dfv = 1;
		cause = 5'h08;
		cy(30);
		chk("req", req, 1);
		dfv = 0;
		hfe = 1;
		cause = 5'h10;
		cy(2);
		chk("req", req, 1);
		hfe = 0;
		ppo = 1;
		pph = 1;
		cy(2);
		chk("req", req, 1);
		chk("tx_err", evr[1], 0);
		pph = 0;
		cy(1);
		ppo = 0;
		cause = 5'h00;
		chk("req", req, 0);
		chk("tx_err", evr[1], 1);
		chk("any_irq", evr[7], 0);
		chk("irq_n", irq_n, 1);
		i_host.bfc(5'h16);
		fd = 1;
		rs = 1;
		cy(1);
		rs = 0;
		cause = 5'h10;
		cy(1);
		cause = 5'h00;
		fd = 0;
		chk("req", req, 0);
		chk("tx_err", evr[1], 1);
		chk("tx_done", evr[3], 1);
		i_host.bfc(5'h16);
	endtask : t_tx_permit
	task automatic t_reset();
		en = 9'h003;
		bf = 1;
		fe = 1;
		cy(1);
		bf = 0;
		fe = 0;
		rst_i = 1;
		cy(1);
		chk("irq_n", irq_n, 1);
		rst_i = 0;
		chk("rx_err", evr[0], 0);
		cy(1);
		chk("rx_err", evr[0], 0);
		chk("abort", abrt, 0);
		chk("irq_n", irq_n, 1);
	endtask : t_reset
	task automatic t_tx_duplex();
		fd = 1;
		rs = 1;
		cy(1);
		rs = 0;
		cause = 5'h04;
		cy(4);
		cause = 5'h00;
		chk("req", req, 1);
		chk("tx_err", evr[1], 0);
		rc = 1;
		cy(1);
		rc = 0;
		fd = 0;
		chk("tx_done", evr[3], 1);
		chk("abort_st", tabs, 0);
		i_host.bfc(5'h04);
		rs = 1;
		cy(1);
		rs = 0;
		cmp = 1;
		cy(1);
		cmp = 0;
		cy(3);
		chk("tx_done", evr[3], 1);
		i_host.bfc(5'h04);
	endtask : t_tx_duplex
	task automatic t_dma();
		en = 9'h021;
		dma = 1;
		cy(2);
		chk("dma_done", evr[5], 0);
		dma = 0;
		cy(4);
		chk("dma_done", evr[5], 1);
		chk("irq_n", irq_n, 0);
		i_host.bfc(5'h08);
	endtask : t_dma
	task automatic t_link();
		en = 9'h011;
		ev = 1;
		cy(1);
		ev = 0;
		chk("link", evr[4], 0);
		chk("irq_n", irq_n, 1);
		i_host.phy_read();
		en = 9'h191;
		ev = 1;
		cy(1);
		ev = 0;
		chk("link", evr[4], 1);
		chk("phy_glb", pg, 1);
		chk("phy_lnk", pl, 1);
		chk("irq_n", irq_n, 0);
		en = 9'h190;
		cy(1);
		chk("irq_n", irq_n, 1);
		i_host.phy_read();
		chk("phy_lnk", pl, 0);
		chk("link", evr[4], 0);
	endtask : t_link
	initial
	begin
		repeat (4) @(posedge clk_i);
		#1 rst_i = 0;
		chk("irq_n", irq_n, 1);
		t_rx_error();
		t_packets();
		for (int i = 0; i < 5; i++) t_tx_abort(i);
		t_tx_duplex();
		t_tx_permit();
		t_dma();
		t_link();
		t_reset();
		report_and_stop();
	end
endmodule : eef_top_tb
